// ---- rtl/ods_phase_top.sv ----
`timescale 1ns/10ps
module ods_phase_top
#(
    parameter int DIV_W = ods_pkg::ODS_DIV_W
)
(
    input wire logic MCLK_I,                                    // synth clock, 250 MHz
    input wire logic SYS_RST_I,                                 // synchronous reset, high
    input wire logic [7:0] REG_ADDR_I,                          // byte register address
    input wire logic [7:0] REG_WDATA_I,                         // byte write data
    input wire logic REG_WR_I,                                  // write strobe
    input wire logic REG_RD_I,                                  // read strobe
    input wire logic [ods_pkg::ODS_NPATH-1:0][DIV_W-1:0] DIV_RATIO_I, // per-path ratio
    output logic [7:0] REG_RDATA_O,                             // read data, one cycle later
    output logic [ods_pkg::ODS_NPATH-1:0] OUT_CLK_O,            // shifted divider clocks
    output logic [ods_pkg::ODS_NPATH-1:0][3:0] FINE_STEP_O,     // signed 45 deg steps
    output logic [ods_pkg::ODS_NPATH-1:0] SLIP_BUSY_O           // coarse slip running
);
    import ods_pkg::*;

    initial
    begin
        if (DIV_W < 2 || DIV_W > 24)
            $error("ods_phase_top: DIV_W out of range");
        if (ODS_NPATH > 8)
            $error("ods_phase_top: path index wider than three bits");
    end

    ods_phase_t staged [ODS_NPATH];
    ods_phase_t next_staged [ODS_NPATH];
    ods_phase_t applied [ODS_NPATH];
    ods_phase_t next_applied [ODS_NPATH];
    logic [ODS_NPATH-1:0] upper_done;
    logic [ODS_NPATH-1:0] next_upper_done;
    logic [ODS_NPATH-1:0] lower_done;
    logic [ODS_NPATH-1:0] next_lower_done;
    logic [ODS_NPATH-1:0] apply;
    logic [ODS_NPATH-1:0] next_apply;
    logic [7:0] next_rdata;
    ods_dec_t wr_dec;
    ods_dec_t rd_dec;

    // map a byte address onto a path and byte half
    function automatic ods_dec_t ods_decode(input logic [7:0] addr);
        ods_dec_t d;
        d = '0;
        for (int i = 0; i < ODS_NPATH; i++)
        begin
            if (addr == ODS_OFS[i])
            begin
                d.hit = 1'b1;
                d.upper = 1'b1;
                d.idx = 3'(i);
            end
            else if (addr == ODS_OFS[i] + 8'h01)
            begin
                d.hit = 1'b1;
                d.upper = 1'b0;
                d.idx = 3'(i);
            end
        end
        return d;
    endfunction

    // byte writes stage, a complete pair commits
    always_comb
    begin
        wr_dec = ods_decode(REG_ADDR_I);
        next_staged = staged;
        next_applied = applied;
        next_upper_done = upper_done;
        next_lower_done = lower_done;
        next_apply = '0;
        if (REG_WR_I && wr_dec.hit)
        begin
            if (wr_dec.upper)
            begin
                next_staged[wr_dec.idx][15:8] = REG_WDATA_I;
                next_upper_done[wr_dec.idx] = 1'b1;
            end
            else
            begin
                next_staged[wr_dec.idx][7:0] = REG_WDATA_I;
                next_lower_done[wr_dec.idx] = 1'b1;
            end
        end
        for (int i = 0; i < ODS_NPATH; i++)
        begin
            if (next_upper_done[i] && next_lower_done[i])
            begin
                next_applied[i] = next_staged[i];
                next_upper_done[i] = 1'b0;
                next_lower_done[i] = 1'b0;
                next_apply[i] = 1'b1;
            end
        end
    end

    // register file state
    always_ff @(posedge MCLK_I)
    begin
        if (SYS_RST_I)
        begin
            for (int i = 0; i < ODS_NPATH; i++)
            begin
                staged[i] <= ODS_PHASE_RST;
                applied[i] <= ODS_PHASE_RST;
            end
            upper_done <= '0;
            lower_done <= '0;
            apply <= '0;
        end
        else
        begin
            staged <= next_staged;
            applied <= next_applied;
            upper_done <= next_upper_done;
            lower_done <= next_lower_done;
            apply <= next_apply;
        end
    end

    // read mux: staged bytes of the addressed path, zero elsewhere
    always_comb
    begin
        rd_dec = ods_decode(REG_ADDR_I);
        next_rdata = 8'h00;                                    // unmapped or idle reads give zero
        if (REG_RD_I && rd_dec.hit)
        begin
            if (rd_dec.upper)
                next_rdata = staged[rd_dec.idx][15:8];         // fine field and coarse top
            else
                next_rdata = staged[rd_dec.idx][7:0];          // coarse low bits
        end
    end

    // read data register, one cycle behind the strobe
    always_ff @(posedge MCLK_I)
    begin
        if (SYS_RST_I)
            REG_RDATA_O <= 8'h00;
        else
            REG_RDATA_O <= next_rdata;
    end

    // one byte per cycle can complete at most one path
    chk_one_commit: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        $onehot0(apply))
        else $error("two paths committed in one cycle");

    // reads outside the six settings answer zero
    chk_unmapped_read: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
        (REG_RD_I && !rd_dec.hit) |=> (REG_RDATA_O == 8'h00))
        else $error("unmapped read returned data");

    // one independent phase engine per divider path
    generate
        for (genvar g = 0; g < ODS_NPATH; g++)
        begin : g_path
            ods_phase_path #(.DIV_W(DIV_W)) u_path (
                .clk_i(MCLK_I),
                .rst_i(SYS_RST_I),
                .ratio_i(DIV_RATIO_I[g]),
                .apply_i(apply[g]),
                .phase_i(applied[g]),
                .clk_o(OUT_CLK_O[g]),
                .fine_step_o(FINE_STEP_O[g]),
                .busy_o(SLIP_BUSY_O[g])
            );

            // a setting moves only when the partner of a pending byte lands
            chk_pair_commit: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
                !(REG_WR_I && wr_dec.hit && wr_dec.idx == 3'(g)
                  && ((upper_done[g] && !wr_dec.upper) || (lower_done[g] && wr_dec.upper)))
                |=> $stable(applied[g]) && !apply[g])
                else $error("setting changed before both bytes written");
            // each commit copies the staged pair and clears both marks
            chk_commit_value: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
                apply[g] |-> (applied[g] == staged[g]) && !upper_done[g] && !lower_done[g])
                else $error("committed value differs from staged bytes");
            // a foreign write leaves this path's stage alone
            chk_path_own: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
                (REG_WR_I && wr_dec.hit && wr_dec.idx != 3'(g)) |=> $stable(staged[g]))
                else $error("write reached another path");
            // the fine output follows bits 15:13 of the committed setting
            chk_field_split: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
                apply[g] ##1 !apply[g] |-> FINE_STEP_O[g] == ods_quad_steps(applied[g].fine))
                else $error("fine field not taken from bits 15:13");
            // a byte write lands in its own half of the stage
            chk_upper_stage: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
                (REG_WR_I && wr_dec.hit && wr_dec.idx == 3'(g) && wr_dec.upper)
                |=> (staged[g][15:8] == $past(REG_WDATA_I)))
                else $error("upper byte not staged");
            chk_lower_stage: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
                (REG_WR_I && wr_dec.hit && wr_dec.idx == 3'(g) && !wr_dec.upper)
                |=> (staged[g][7:0] == $past(REG_WDATA_I)))
                else $error("lower byte not staged");
            // reads return the staged bytes one cycle later
            chk_read_upper: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
                (REG_RD_I && rd_dec.hit && rd_dec.idx == 3'(g) && rd_dec.upper)
                |=> (REG_RDATA_O == $past(staged[g][15:8])))
                else $error("upper byte read back wrong");
            chk_read_lower: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
                (REG_RD_I && rd_dec.hit && rd_dec.idx == 3'(g) && !rd_dec.upper)
                |=> (REG_RDATA_O == $past(staged[g][7:0])))
                else $error("lower byte read back wrong");
            // a half-written setting stays pending until its partner byte
            chk_upper_wait: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
                (upper_done[g] && !(REG_WR_I && wr_dec.hit && wr_dec.idx == 3'(g)))
                |=> upper_done[g])
                else $error("pending upper byte lost");
            chk_lower_wait: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
                (lower_done[g] && !(REG_WR_I && wr_dec.hit && wr_dec.idx == 3'(g)))
                |=> lower_done[g])
                else $error("pending lower byte lost");
            chk_no_double: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
                !(upper_done[g] && lower_done[g]))
                else $error("both bytes pending without commit");
        end
    endgenerate

endmodule

// ---- rtl/ods_pkg.sv ----
// shared layout and map of the divider phase offset registers
package ods_pkg;

    // number of divider paths served: synth2 B/C/D, synth3 A/B/C
    localparam int ODS_NPATH = 6;
    localparam int ODS_DIV_W = 16;

    // first byte address of each 16-bit setting; upper byte there, lower byte at +1
    localparam logic [7:0] ODS_OFS_S2_B = 8'hCD;
    localparam logic [7:0] ODS_OFS_S2_C = 8'hCF;
    localparam logic [7:0] ODS_OFS_S2_D = 8'hD1;
    localparam logic [7:0] ODS_OFS_S3_A = 8'hD3;
    localparam logic [7:0] ODS_OFS_S3_B = 8'hD5;
    localparam logic [7:0] ODS_OFS_S3_C = 8'hD7;
    localparam logic [7:0] ODS_OFS [ODS_NPATH] = '{ODS_OFS_S2_B, ODS_OFS_S2_C,
        ODS_OFS_S2_D, ODS_OFS_S3_A, ODS_OFS_S3_B, ODS_OFS_S3_C};

    // field positions inside one setting
    localparam int ODS_COARSE_LSB = 0;
    localparam int ODS_COARSE_W = 13;
    localparam int ODS_FINE_LSB = 13;
    localparam int ODS_FINE_W = 3;
    localparam logic [15:0] ODS_PHASE_RST = 16'h0000;

    // quadrature codes
    localparam logic [2:0] ODS_Q_0 = 3'h0;
    localparam logic [2:0] ODS_Q_M45 = 3'h1;
    localparam logic [2:0] ODS_Q_M90 = 3'h2;
    localparam logic [2:0] ODS_Q_M135 = 3'h3;
    localparam logic [2:0] ODS_Q_180 = 3'h4;
    localparam logic [2:0] ODS_Q_P135 = 3'h5;
    localparam logic [2:0] ODS_Q_P90 = 3'h6;
    localparam logic [2:0] ODS_Q_P45 = 3'h7;

    // one 16-bit setting: fine angle on top, coarse period count below
    typedef struct packed {
        logic [ODS_FINE_W-1:0] fine;
        logic signed [ODS_COARSE_W-1:0] coarse;
    } ods_phase_t;

    // decoded byte address
    typedef struct packed {
        logic hit;
        logic upper;
        logic [2:0] idx;
    } ods_dec_t;

    // quadrature code to signed count of 45-degree steps
    function automatic logic signed [3:0] ods_quad_steps(input logic [2:0] code);
        logic signed [3:0] s;
        s = 4'sh0;
        case (code)
            ODS_Q_0: s = 4'sh0;
            ODS_Q_M45: s = -4'sh1;
            ODS_Q_M90: s = -4'sh2;
            ODS_Q_M135: s = -4'sh3;
            ODS_Q_180: s = 4'sh4;
            ODS_Q_P135: s = 4'sh3;
            ODS_Q_P90: s = 4'sh2;
            ODS_Q_P45: s = 4'sh1;
            default: s = 4'sh0;
        endcase
        return s;
    endfunction

endpackage

// ---- rtl/ods_phase_path.sv ----
`timescale 1ns/10ps
// one post-divider path: divides the synth clock and slips its phase
module ods_phase_path
#(
    parameter int DIV_W = ods_pkg::ODS_DIV_W
)
(
    input wire logic clk_i,                        // synthesizer clock
    input wire logic rst_i,                        // synchronous reset, high
    input wire logic [DIV_W-1:0] ratio_i,          // divide ratio, 2 or more
    input wire logic apply_i,                      // new setting valid, one cycle
    input wire ods_pkg::ods_phase_t phase_i,       // setting to take
    output logic clk_o,                            // divided, shifted clock
    output logic signed [3:0] fine_step_o,         // quadrature shift, 45 deg units
    output logic busy_o                            // coarse slip still running
);
    import ods_pkg::*;

    initial
    begin
        if (DIV_W < 2 || DIV_W > 24)
            $error("ods_phase_path: DIV_W out of range");
    end

    logic [DIV_W-1:0] cnt;
    logic [DIV_W-1:0] next_cnt;
    logic signed [16:0] slip;
    logic signed [16:0] next_slip;
    logic signed [ODS_COARSE_W-1:0] cur_coarse;
    logic signed [ODS_COARSE_W-1:0] next_coarse;
    logic signed [3:0] next_fine_step;
    logic next_clk;
    logic [1:0] step;
    logic [DIV_W:0] sum;

    // slip engine: positive slip advances, negative slip delays, one period per cycle
    always_comb
    begin
        next_slip = slip;
        next_coarse = cur_coarse;
        next_fine_step = fine_step_o;
        step = 2'd1;
        if (slip > 17'sd0)
        begin
            step = 2'd2;                           // skip a synth period
            next_slip = slip - 17'sd1;
        end
        else if (slip < 17'sd0)
        begin
            step = 2'd0;                           // hold for a synth period
            next_slip = slip + 17'sd1;
        end
        if (apply_i)
        begin
            // only the change from the last setting is slipped
            next_slip = next_slip + 17'(phase_i.coarse) - 17'(cur_coarse);
            next_coarse = phase_i.coarse;
            next_fine_step = ods_quad_steps(phase_i.fine);
        end
        sum = {1'b0, cnt} + (DIV_W+1)'(step);
        if (sum >= {1'b0, ratio_i})
            sum = sum - {1'b0, ratio_i};
        if (sum >= {1'b0, ratio_i})
            sum = '0;
        next_cnt = sum[DIV_W-1:0];
        next_clk = (next_cnt < (ratio_i >> 1));
    end

    // register the path state
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cnt <= '0;
            slip <= '0;
            cur_coarse <= '0;
            fine_step_o <= '0;
            clk_o <= 1'b0;
            busy_o <= 1'b0;
        end
        else
        begin
            cnt <= next_cnt;
            slip <= next_slip;
            cur_coarse <= next_coarse;
            fine_step_o <= next_fine_step;
            clk_o <= next_clk;
            busy_o <= (next_slip != 17'sd0);
        end
    end

    chk_advance_slip: assert property (@(posedge clk_i) disable iff (rst_i)
        (slip > 17'sd0 && !apply_i) |=> (slip == $past(slip) - 17'sd1))
        else $error("advance slip did not count down");
    chk_delay_slip: assert property (@(posedge clk_i) disable iff (rst_i)
        (slip < 17'sd0 && !apply_i) |=> (slip == $past(slip) + 17'sd1))
        else $error("delay slip did not count up");
    chk_zero_steady: assert property (@(posedge clk_i) disable iff (rst_i)
        (slip == 17'sd0 && !apply_i) |=> (slip == 17'sd0) && !busy_o)
        else $error("zero shift moved the phase");
    chk_coarse_load: assert property (@(posedge clk_i) disable iff (rst_i)
        apply_i |=> (cur_coarse == $past(phase_i.coarse)))
        else $error("coarse setting not taken");
    chk_fine_half: assert property (@(posedge clk_i) disable iff (rst_i)
        (apply_i && phase_i.fine == 3'h4) |=> (fine_step_o == 4'sh4))
        else $error("code 100 not 180 degrees");
    chk_fine_m135: assert property (@(posedge clk_i) disable iff (rst_i)
        (apply_i && phase_i.fine == 3'h3) |=> (fine_step_o == -4'sh3))
        else $error("code 011 not minus 135 degrees");
    chk_fine_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        !apply_i |=> $stable(fine_step_o))
        else $error("fine shift changed without a new setting");

endmodule

// ---- sim/ods_phase_top_tb.sv ----
`timescale 1ns/10ps
module ods_phase_top_tb;
    import ods_pkg::*;

    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [ODS_NPATH-1:0][15:0] ratio = {ODS_NPATH{16'h0010}};
    logic [7:0] rdata;
    logic [ODS_NPATH-1:0] out_clk;
    logic [ODS_NPATH-1:0][3:0] fine_step;
    logic [ODS_NPATH-1:0] slip_busy;
    logic [ODS_NPATH-1:0] prev_clk = '0;
    int fails = 0;
    int n_checks = 0;
    int n;
    // expected signed step count per quadrature code
    localparam logic [3:0] QEXP [8] = '{4'h0, 4'hF, 4'hE, 4'hD, 4'h4, 4'h3, 4'h2, 4'h1};

    ods_phase_top i_ods_phase_top (
        .MCLK_I(mclk), .SYS_RST_I(rst), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
        .REG_WR_I(wr_en), .REG_RD_I(rd_en), .DIV_RATIO_I(ratio), .REG_RDATA_O(rdata),
        .OUT_CLK_O(out_clk), .FINE_STEP_O(fine_step), .SLIP_BUSY_O(slip_busy)
    );

    // 250 MHz clock
    always #2 mclk = ~mclk;

    // last sampled divider clocks, for edge detection
    always @(negedge mclk) prev_clk <= out_clk;

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            fails++;
        end
    endtask

    // one byte write, strobe held over one rising edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr_en = 1'b1;
        @(negedge mclk);
        wr_en = 1'b0;
        @(negedge mclk);                  // idle cycle, strobe never retoggled in one step
    endtask

    // one byte read, data checked in the cycle after the strobe edge
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        addr = a;
        rd_en = 1'b1;
        @(negedge mclk);
        rd_en = 1'b0;
        chk({8'h00, rdata}, {8'h00, exp});
        @(negedge mclk);                  // idle cycle before the next strobe
    endtask

    // full setting: upper byte at base, lower byte at base+1, then settle
    task automatic wr16(input int p, input logic [15:0] v);
        wr(ODS_OFS[p], v[15:8]);
        wr(ODS_OFS[p] + 8'h01, v[7:0]);
        repeat (2) @(negedge mclk);
    endtask

    // cycles from a rising edge of path p to the next one of reference path 5
    task automatic meas(input int p, output int cnt);
        int k;
        k = 0;
        @(negedge mclk);
        while (!(out_clk[p] === 1'b1 && prev_clk[p] === 1'b0) && k < 40)
        begin
            @(negedge mclk);
            k++;
        end
        cnt = 0;
        while (!(out_clk[5] === 1'b1 && prev_clk[5] === 1'b0) && cnt < 40)
        begin
            @(negedge mclk);
            cnt++;
        end
    endtask

    // coarse shift: busy seen, slip finishes in bounded time, offset measured
    task automatic coarse(input int p, input logic [15:0] v, input int exp);
        int k;
        wr(ODS_OFS[p], v[15:8]);
        wr(ODS_OFS[p] + 8'h01, v[7:0]);
        // busy is sampled right after the slip loads, so a one-period slip is seen
        chk({15'h0000, slip_busy[p]}, 16'h0001);
        k = 0;
        while (slip_busy[p] !== 1'b0 && k < 40)
        begin
            @(negedge mclk);
            k++;
        end
        chk({15'h0000, slip_busy[p]}, 16'h0000);
        meas(p, n);
        chk(16'(n), 16'(exp));
    endtask

    // watchdog
    initial
    begin
        #40000;
        fails++;
        end_of_test();
    end

    initial
    begin
        repeat (4) @(negedge mclk);
        rst = 1'b0;
        // reset values of every byte, and unmapped neighbours
        for (int p = 0; p < ODS_NPATH; p++)
        begin
            rd(ODS_OFS[p], 8'h00);
            rd(ODS_OFS[p] + 8'h01, 8'h00);
            chk({12'h000, fine_step[p]}, 16'h0000);
        end
        rd(8'hCC, 8'h00);
        rd(8'hD9, 8'h00);
        wr(8'hD9, 8'hFF);
        rd(8'hD9, 8'h00);
        // all eight quadrature codes on one path
        for (int c = 0; c < 8; c++)
        begin
            wr16(1, {3'(c), 13'h0000});
            chk({12'h000, fine_step[1]}, {12'h000, QEXP[c]});
            chk({12'h000, fine_step[0]}, 16'h0000);
        end
        // upper byte alone must not take effect
        wr(ODS_OFS[3], 8'hA0);
        repeat (4) @(negedge mclk);
        chk({12'h000, fine_step[3]}, 16'h0000);
        rd(ODS_OFS[3], 8'hA0);
        wr(ODS_OFS[3] + 8'h01, 8'h00);
        repeat (2) @(negedge mclk);
        chk({12'h000, fine_step[3]}, {12'h000, QEXP[5]});
        // lower byte first also commits
        wr(ODS_OFS[4] + 8'h01, 8'h00);
        wr(ODS_OFS[4], 8'hE0);
        repeat (2) @(negedge mclk);
        chk({12'h000, fine_step[4]}, {12'h000, QEXP[7]});
        // every path keeps its own setting
        for (int p = 0; p < ODS_NPATH; p++)
            wr16(p, {3'(p + 1), 13'h0000});
        for (int p = 0; p < ODS_NPATH; p++)
            chk({12'h000, fine_step[p]}, {12'h000, QEXP[p + 1]});
        // zero coarse: path aligned with reference
        meas(0, n);
        chk(16'(n), 16'h0000);
        // advance 3, then delay 2, then delay 1 on another path
        coarse(0, 16'h2003, 3);
        rd(ODS_OFS[0] + 8'h01, 8'h03);
        coarse(0, 16'h3FFE, 14);
        coarse(2, 16'h7FFF, 15);
        chk({12'h000, fine_step[2]}, {12'h000, QEXP[3]});
        end_of_test();
    end
endmodule
